// file: rtl/mpm_defs.svh
// Constants for the memory page mapper: register reset, field positions and map bounds.
`ifndef MPM_DEFS_SVH
`define MPM_DEFS_SVH

`define MPM_PAGE_SEL_RST 8'h00
`define MPM_IO_ADDR_DEF 16'hFF80
`define MPM_EPR_A15_BIT 1
`define MPM_EPR_A16_BIT 0
`define MPM_SRAM_A15_BIT 3
`define MPM_SRAM_A16_BIT 2
`define MPM_MULTI_LSB 4
`define MPM_IO_REGION_HI 8'hFF
`define MPM_MODE_RST 2'h0

`endif

// file: rtl/mpm_pkg.sv
// Types for the memory page mapper.
package mpm_pkg;

  typedef enum logic [1:0] {
    MPM_MODE_STD,
    MPM_MODE_MULTI_CODE,
    MPM_MODE_MULTI_DATA,
    MPM_MODE_RSVD
  } mpm_mode_t;

  typedef struct packed {
    logic [15:0] addr;
    logic code_rd;
    logic data_rd;
    logic data_wr;
  } mpm_bus_t;

  typedef struct packed {
    logic eprom_cs;
    logic [1:0] eprom_hi;
    logic sram_cs;
    logic [1:0] sram_hi;
    logic multi_cs;
    logic [3:0] multi_hi;
  } mpm_mem_t;

endpackage

// file: rtl/mpm_mapper.sv
// Memory page mapper: page-select register in I/O space and socket decoding.
// Operation
// - Page sockets into code and data windows.
// - Page-select register lives in I/O space.
// - Bits 1,0 drive EPROM A15,A16.
// - Bits 3,2 drive SRAM A15,A16.
// - Bits 7..4 drive multi socket A18..A15.
// - Reset clears page-select register.
// - Cleared: EPROM low half, SRAM high.
// - Each socket uses only its bits.
// - Code and data cycles decoded separately.
`timescale 1ns/1ps
`include "mpm_defs.svh"

module mpm_mapper (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input mpm_pkg::mpm_bus_t bus_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [15:0] io_addr_i,
  input wire logic [7:0] io_wdata_i,
  input mpm_pkg::mpm_mode_t mode_i,
  output logic [7:0] io_rdata_o,
  output logic io_rvalid_o,
  output mpm_pkg::mpm_mem_t mem_o
);
  import mpm_pkg::*;

  // ----------------------------------------
  // I/O address decode
  // ----------------------------------------
  logic sel_hit;
  logic sel_wr;
  logic sel_rd;

  // The page-select register answers one I/O address only.
  assign sel_hit = (io_addr_i == `MPM_IO_ADDR_DEF);
  assign sel_wr = io_wr_i & sel_hit;
  assign sel_rd = io_rd_i & sel_hit;

  // ----------------------------------------
  // Page-select register
  // ----------------------------------------
  logic [7:0] page_sel_q;

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      page_sel_q <= `MPM_PAGE_SEL_RST;
    end else if (sel_wr) begin
      page_sel_q <= io_wdata_i;
    end
  end

  // ----------------------------------------
  // Read-back
  // ----------------------------------------
  // Every I/O read is answered one cycle later, even when it misses the register.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      io_rvalid_o <= 1'b0;
    end else begin
      io_rvalid_o <= io_rd_i;
    end
  end

  // Reads of any other I/O address return zero with the same one-cycle latency.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      io_rdata_o <= 8'h00;
    end else if (sel_rd) begin
      io_rdata_o <= page_sel_q;
    end else begin
      io_rdata_o <= 8'h00;
    end
  end

  // ----------------------------------------
  // Socket address lines
  // ----------------------------------------
  logic [1:0] eprom_hi_d;
  logic [1:0] sram_hi_d;
  logic [3:0] multi_hi_d;

  // Upper address lines always follow their own bit group.
  assign eprom_hi_d = {page_sel_q[`MPM_EPR_A16_BIT], page_sel_q[`MPM_EPR_A15_BIT]};
  assign sram_hi_d = {page_sel_q[`MPM_SRAM_A16_BIT], page_sel_q[`MPM_SRAM_A15_BIT]};

  // Each multi socket line follows one register bit, A15 from the lowest bit of the group.
  for (genvar gi = 0; gi < 4; gi++) begin : g_multi_line
    assign multi_hi_d[gi] = page_sel_q[`MPM_MULTI_LSB + gi];
  end

  // ----------------------------------------
  // Cycle classification
  // ----------------------------------------
  logic io_region;
  logic hi_half;
  logic code_cyc;
  logic data_cyc;

  // The top page belongs to on-board I/O, so no memory cycle is seen there.
  assign io_region = (bus_i.addr[15:8] == `MPM_IO_REGION_HI);
  assign hi_half = bus_i.addr[15];
  // A code fetch wins over a data strobe that should never come with it.
  assign code_cyc = bus_i.code_rd & !io_region;
  assign data_cyc = (bus_i.data_rd | bus_i.data_wr) & !bus_i.code_rd & !io_region;

  // ----------------------------------------
  // Program EPROM select
  // ----------------------------------------
  logic eprom_cs_d;

  always_comb begin
    eprom_cs_d = 1'b0;
    case (mode_i)
      MPM_MODE_MULTI_DATA: begin
        eprom_cs_d = code_cyc;
      end
      default: begin
        eprom_cs_d = code_cyc & !hi_half;
      end
    endcase
  end

  // ----------------------------------------
  // SRAM select
  // ----------------------------------------
  logic sram_cs_d;

  always_comb begin
    sram_cs_d = 1'b0;
    case (mode_i)
      MPM_MODE_MULTI_DATA: begin
        sram_cs_d = data_cyc & !hi_half;
      end
      default: begin
        sram_cs_d = data_cyc & hi_half;
      end
    endcase
  end

  // ----------------------------------------
  // Multi-type socket select
  // ----------------------------------------
  logic multi_cs_d;

  always_comb begin
    multi_cs_d = 1'b0;
    case (mode_i)
      MPM_MODE_MULTI_CODE: begin
        multi_cs_d = code_cyc & hi_half;
      end
      MPM_MODE_MULTI_DATA: begin
        multi_cs_d = data_cyc & hi_half;
      end
      default: begin
        multi_cs_d = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // Memory side outputs
  // ----------------------------------------
  mpm_mem_t mem_d;
  mpm_mem_t mem_q;

  always_comb begin
    mem_d = '0;
    mem_d.eprom_cs = eprom_cs_d;
    mem_d.eprom_hi = eprom_hi_d;
    mem_d.sram_cs = sram_cs_d;
    mem_d.sram_hi = sram_hi_d;
    mem_d.multi_cs = multi_cs_d;
    mem_d.multi_hi = multi_hi_d;
  end

  // Registering the map keeps every memory-side line glitch free.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mem_q <= '0;
    end else begin
      mem_q <= mem_d;
    end
  end

  assign mem_o = mem_q;

endmodule

// file: tb/mpm_monitor.sv
// Port checker.
`timescale 1ns/1ps
module mpm_monitor (input logic mclk_i, sys_rst_i, io_wr_i, io_rd_i, io_rvalid_o,
  input logic [15:0] io_addr_i, input logic [7:0] io_wdata_i, io_rdata_o,
  input mpm_pkg::mpm_bus_t bus_i, input mpm_pkg::mpm_mode_t mode_i,
  input mpm_pkg::mpm_mem_t mem_o);
  logic [7:0] p1, p2;
  wire w = io_wr_i && io_addr_i == 16'hff80;
  wire s = mode_i == 0;
  always_ff @(posedge mclk_i) {p2, p1} <= {p1, io_wdata_i};
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  rd_ans_a: assert property (io_rd_i |=> io_rvalid_o) else $error("read");
  rd_idle_a: assert property (!io_rd_i |=> !io_rvalid_o) else $error("idle");
  epr_pg_a: assert property (w |=> ##1 mem_o.eprom_hi == {p2[0], p2[1]}) else $error("ep");
  sram_pg_a: assert property (w |=> ##1 mem_o.sram_hi == {p2[2], p2[3]}) else $error("sp");
  multi_pg_a: assert property (w |=> ##1 mem_o.multi_hi == p2[7:4]) else $error("mp");
  io_hole_a: assert property (&bus_i.addr[15:8] |=>
    !(mem_o.eprom_cs | mem_o.sram_cs | mem_o.multi_cs)) else $error("io");
  code_lo_a: assert property (s && bus_i.code_rd && !bus_i.addr[15] |=>
    mem_o.eprom_cs) else $error("code");
  data_hi_a: assert property (s && bus_i.data_rd && bus_i.addr[15:14] == 2'h2 |=>
    mem_o.sram_cs && !mem_o.eprom_cs) else $error("data");
endmodule
bind mpm_mapper mpm_monitor u_mon (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .io_wr_i(io_wr_i),
  .io_rd_i(io_rd_i), .io_rvalid_o(io_rvalid_o), .io_addr_i(io_addr_i),
  .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .bus_i(bus_i), .mode_i(mode_i),
  .mem_o(mem_o));

// file: tb/mpm_cpu_model.sv
// Processor bus model: registers the requested cycle and holds it on the bus for as long as a_i and k_i stay unchanged.
`timescale 1ns/1ps
module mpm_cpu_model (input logic mclk_i, input logic [15:0] a_i, input logic [1:0] k_i,
  output mpm_pkg::mpm_bus_t bus_o);
  always_ff @(posedge mclk_i) bus_o <= '{a_i, k_i == 2'h1, k_i == 2'h2, k_i == 2'h3};
endmodule

// file: tb/mpm_mapper_tb.sv
// Self-checking bench for the page mapper.
`timescale 1ns/1ps
module mpm_mapper_tb;
  logic mclk_i = 0, sys_rst_i = 1, wr = 0, rd = 0, rv;
  logic [15:0] ia = 0, a = 0;
  logic [7:0] wd = 0, rdat;
  logic [1:0] k = 0;
  mpm_pkg::mpm_bus_t bus;
  mpm_pkg::mpm_mem_t m;
  mpm_pkg::mpm_mode_t md = mpm_pkg::MPM_MODE_STD;
  int error_cnt = 0, n_tests = 0;
  always #12.5 mclk_i = ~mclk_i;
  mpm_cpu_model u_cpu (.mclk_i, .a_i(a), .k_i(k), .bus_o(bus));
  mpm_mapper u_dut (.mclk_i, .sys_rst_i, .bus_i(bus), .io_wr_i(wr), .io_rd_i(rd),
    .io_addr_i(ia), .io_wdata_i(wd), .mode_i(md), .io_rdata_o(rdat),
    .io_rvalid_o(rv), .mem_o(m));
  task cmp(input logic [10:0] g, e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task io(input logic w, input logic [15:0] ad, input logic [7:0] d);
    @(posedge mclk_i);
    {wr, rd, ia, wd} <= {w, !w, ad, d};
    @(posedge mclk_i);
    {wr, rd} <= 2'h0;
    #1;
  endtask
  task cyc(input logic [15:0] ad, input logic [1:0] kd, input logic [10:0] e);
    @(posedge mclk_i);
    {a, k} <= {ad, kd};
    repeat (2) @(posedge mclk_i);
    #1 cmp(m, e);
  endtask
  task t_rst;
    io(0, 16'hff80, 8'h00);
    cmp({rv, rdat}, 11'h100);
    cyc(16'h0123, 1, 11'h400);
    cyc(16'h8123, 2, 11'h080);
    $display("reset test done");
  endtask
  task t_page;
    io(1, 16'hff80, 8'ha5);
    io(1, 16'hff81, 8'h00);
    io(0, 16'hff80, 8'h00);
    cmp({rv, rdat}, 11'h1a5);
    cyc(16'h0010, 1, 11'h64a);
    cyc(16'h8123, 2, 11'h2ca);
    cyc(16'h0010, 2, 11'h24a);
    cyc(16'hff10, 2, 11'h24a);
    $display("page test done");
  endtask
  task t_mode;
    @(posedge mclk_i);
    md <= mpm_pkg::MPM_MODE_MULTI_CODE;
    cyc(16'h8010, 1, 11'h25a);
    cyc(16'h0010, 1, 11'h64a);
    @(posedge mclk_i);
    md <= mpm_pkg::MPM_MODE_MULTI_DATA;
    cyc(16'h8010, 2, 11'h25a);
    cyc(16'h0010, 2, 11'h2ca);
    cyc(16'h9010, 1, 11'h64a);
    @(posedge mclk_i);
    md <= mpm_pkg::MPM_MODE_STD;
    $display("mode test done");
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge mclk_i);
    sys_rst_i <= 0;
    t_rst;
    t_page;
    t_mode;
    wrap_up;
  end
endmodule
